// >>> rtl/mac_config_bank.sv
// Purpose: algorithm configuration register bank
// Assumes: word access from the serial protocol parser, one per cycle
// Assumes: offsets are word addresses of the serial register protocol
// Notes: read answers come from flops, one cycle after the strobe
// Notes: only the speed detect word at 80h is decoded to controls
// Notes: blanking_ns counts in units of 10 ns, 0.25 us reads as 25
`timescale 1ns/1ns
`default_nettype none
`include "mac_regs.svh"

module mac_config_bank
    import mac_pkg::*;
#(
    parameter int NUM_WORDS = 14
) (
    // clock and reset
    input  wire logic               clk_sys,
    input  wire logic               resetn,
    // word access from protocol parser
    input  wire logic               wr_en,
    input  wire logic               rd_en,
    input  wire logic [7:0]         addr,
    input  wire logic [31:0]        wr_data,
    output logic [31:0]             rd_data,
    output logic                    rd_valid,
    // decoded controls and raw config words to the motor algorithm
    output mac_detect_ctl_t         detect_ctl,
    output logic [NUM_WORDS*32-1:0] cfg_words
);

    // ==========================================================
    // address map
    localparam logic [7:0] OFS_TABLE [NUM_WORDS] = '{
        `MAC_OFS_SPEED_DETECT,   // word 0, speed detect
        `MAC_OFS_REVERSE_DRIVE,  // word 1, reverse drive
        `MAC_OFS_STARTUP_A,      // word 2, startup a
        `MAC_OFS_STARTUP_B,      // word 3, startup b
        `MAC_OFS_REGULATION_A,   // word 4, regulation a
        `MAC_OFS_REGULATION_B,   // word 5, regulation b
        `MAC_OFS_REGULATION_C,   // word 6, regulation c
        `MAC_OFS_REGULATION_D,   // word 7, regulation d
        `MAC_OFS_CURVE_A,        // word 8, setpoint curve a
        `MAC_OFS_CURVE_B,        // word 9, setpoint curve b
        `MAC_OFS_CURVE_C,        // word 10, setpoint curve c
        `MAC_OFS_CURVE_D,        // word 11, setpoint curve d
        `MAC_OFS_CURVE_E,        // word 12, setpoint curve e
        `MAC_OFS_CURVE_F         // word 13, setpoint curve f
    };

    logic [31:0]          word_r [NUM_WORDS];
    logic [NUM_WORDS-1:0] hit;

    // ==========================================================
    // storage, one word per listed offset
    genvar g;
    generate
        for (g = 0; g < NUM_WORDS; g++) begin : g_word
            assign hit[g] = (addr == OFS_TABLE[g]);  // unlisted offsets hit nothing
            assign cfg_words[g*32 +: 32] = word_r[g];
            // hold until rewritten or reset
            always_ff @(posedge clk_sys) begin
                if (!resetn) begin
                    word_r[g] <= `MAC_RESET_WORD;
                end else if (wr_en && hit[g]) begin
                    word_r[g] <= wr_data;
                end
            end
        end
    endgenerate

    // ==========================================================
    // read path, no side effects
    logic [31:0] rd_mux;
    always_comb begin
        rd_mux = `MAC_UNMAPPED_READ;
        for (int i = 0; i < NUM_WORDS; i++) begin
            if (hit[i]) begin
                rd_mux = word_r[i];
            end
        end
    end

    // read strobe answered exactly one cycle later
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rd_valid <= 1'b0;
        end else begin
            rd_valid <= rd_en;
        end
    end

    // read data stands until the next read
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            rd_data <= `MAC_RESET_WORD;
        end else if (rd_en) begin
            rd_data <= rd_mux;
        end
    end

    // ==========================================================
    // speed detect word fields, word 0 sits at 80h
    logic [31:0] sd;
    logic [3:0]  thr_code;
    logic [3:0]  blank_code;
    logic [6:0]  thr_pct_nxt;
    logic [9:0]  blank_dly_nxt;
    logic        detect_en_r;
    logic        brake_en_r;
    logic        float_en_r;
    logic        reverse_en_r;
    logic        catch_en_r;
    logic [6:0]  thr_pct_r;
    logic [9:0]  blank_dly_r;

    assign sd         = word_r[0];
    assign thr_code   = sd[`MAC_THR_MSB:`MAC_THR_LSB];
    assign blank_code = sd[`MAC_BLANK_MSB:`MAC_BLANK_LSB];

    // ==========================================================
    // resync threshold, percent of maximum speed
    always_comb begin
        case (thr_code)  // 5..60 by 5, then 70..100 by 10
            4'h0: begin
                thr_pct_nxt = 7'h05;
            end
            4'h1: begin
                thr_pct_nxt = 7'h0a;
            end
            4'h2: begin
                thr_pct_nxt = 7'h0f;
            end
            4'h3: begin
                thr_pct_nxt = 7'h14;
            end
            4'h4: begin
                thr_pct_nxt = 7'h19;
            end
            4'h5: begin
                thr_pct_nxt = 7'h1e;
            end
            4'h6: begin
                thr_pct_nxt = 7'h23;
            end
            4'h7: begin
                thr_pct_nxt = 7'h28;
            end
            4'h8: begin
                thr_pct_nxt = 7'h2d;
            end
            4'h9: begin
                thr_pct_nxt = 7'h32;
            end
            4'ha: begin
                thr_pct_nxt = 7'h37;
            end
            4'hb: begin
                thr_pct_nxt = 7'h3c;
            end
            4'hc: begin
                thr_pct_nxt = 7'h46;
            end
            4'hd: begin
                thr_pct_nxt = 7'h50;
            end
            4'he: begin
                thr_pct_nxt = 7'h5a;
            end
            4'hf: begin
                thr_pct_nxt = 7'h64;
            end
            default: begin
                thr_pct_nxt = 7'h05;
            end
        endcase
    end

    // ==========================================================
    // blanking delay before current sampling, 10 ns units
    always_comb begin
        case (blank_code)  // 0.25..2.5 us by 0.25, then longer
            4'h0: begin
                blank_dly_nxt = 10'h019;
            end
            4'h1: begin
                blank_dly_nxt = 10'h032;
            end
            4'h2: begin
                blank_dly_nxt = 10'h04b;
            end
            4'h3: begin
                blank_dly_nxt = 10'h064;
            end
            4'h4: begin
                blank_dly_nxt = 10'h07d;
            end
            4'h5: begin
                blank_dly_nxt = 10'h096;
            end
            4'h6: begin
                blank_dly_nxt = 10'h0af;
            end
            4'h7: begin
                blank_dly_nxt = 10'h0c8;
            end
            4'h8: begin
                blank_dly_nxt = 10'h0e1;
            end
            4'h9: begin
                blank_dly_nxt = 10'h0fa;
            end
            4'ha: begin
                blank_dly_nxt = 10'h12c;
            end
            4'hb: begin
                blank_dly_nxt = 10'h15e;
            end
            4'hc: begin
                blank_dly_nxt = 10'h190;
            end
            4'hd: begin
                blank_dly_nxt = 10'h1c2;
            end
            4'he: begin
                blank_dly_nxt = 10'h1f4;
            end
            4'hf: begin
                blank_dly_nxt = 10'h258;
            end
            default: begin
                blank_dly_nxt = 10'h019;
            end
        endcase
    end

    // ==========================================================
    // decoded controls, one flop per field
    // speed detection on or off
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            detect_en_r <= 1'b0;
        end else begin
            detect_en_r <= sd[`MAC_BIT_DETECT_EN];
        end
    end

    // braking permitted in the start sequence
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            brake_en_r <= 1'b0;
        end else begin
            brake_en_r <= sd[`MAC_BIT_BRAKE_EN];
        end
    end

    // floating outputs permitted in the start sequence
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            float_en_r <= 1'b0;
        end else begin
            float_en_r <= sd[`MAC_BIT_FLOAT_EN];
        end
    end

    // reverse drive on or off
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            reverse_en_r <= 1'b0;
        end else begin
            reverse_en_r <= sd[`MAC_BIT_REVERSE_EN];
        end
    end

    // catching a spinning motor on or off
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            catch_en_r <= 1'b0;
        end else begin
            catch_en_r <= sd[`MAC_BIT_CATCH_EN];
        end
    end

    // resync threshold in percent
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            thr_pct_r <= 7'h00;
        end else begin
            thr_pct_r <= thr_pct_nxt;
        end
    end

    // blanking delay, wide enough for the longest code
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            blank_dly_r <= 10'h000;
        end else begin
            blank_dly_r <= blank_dly_nxt;
        end
    end

    // controls out, straight from the field flops
    assign detect_ctl = '{
        speed_detect_enable:        detect_en_r,
        brake_enable:               brake_en_r,
        start_float_enable:         float_en_r,
        reverse_drive_enable:       reverse_en_r,
        catch_spin_enable:          catch_en_r,
        catch_spin_speed_threshold: thr_pct_r,
        blanking_ns:                blank_dly_r
    };

endmodule
`default_nettype wire

// >>> rtl/mac_pkg.sv
// Purpose: types of the config bank
// Assumes: none
// Notes: none
package mac_pkg;
    // decoded speed detect controls
    typedef struct packed {
        logic       speed_detect_enable;
        logic       brake_enable;
        logic       start_float_enable;
        logic       reverse_drive_enable;
        logic       catch_spin_enable;
        logic [6:0] catch_spin_speed_threshold;  // percent of max speed
        logic [9:0] blanking_ns;                 // sample delay, 10 ns units
    } mac_detect_ctl_t;
endpackage

// >>> rtl/mac_regs.svh
// Purpose: offsets, field positions and reset values of the config bank
// Assumes: 32-bit words at even offsets 80h..8eh and 94h..9eh
// Notes: offsets are word indices of the serial register protocol
// Operation
// - speed detect word sits at 80h, resets to all zeros.
// - bit 30 turns initial speed detection on or off.
// - bit 29 permits braking during the start sequence.
// - bit 28 permits a floating output phase during start sequence.
// - bit 27 enables reverse drive.
// - bit 26 enables catching a spinning motor.
// - bits 25-22 pick resync minimum speed, 5..60% by 5, then 70..100%.
// - bits 20-17 pick current sampling blanking delay after a pwm edge.
`ifndef MAC_REGS_SVH
`define MAC_REGS_SVH

// ==========================================================
// register offsets
`define MAC_OFS_SPEED_DETECT   8'h80
`define MAC_OFS_REVERSE_DRIVE  8'h82
`define MAC_OFS_STARTUP_A      8'h84
`define MAC_OFS_STARTUP_B      8'h86
`define MAC_OFS_REGULATION_A   8'h88
`define MAC_OFS_REGULATION_B   8'h8a
`define MAC_OFS_REGULATION_C   8'h8c
`define MAC_OFS_REGULATION_D   8'h8e
`define MAC_OFS_CURVE_A        8'h94
`define MAC_OFS_CURVE_B        8'h96
`define MAC_OFS_CURVE_C        8'h98
`define MAC_OFS_CURVE_D        8'h9a
`define MAC_OFS_CURVE_E        8'h9c
`define MAC_OFS_CURVE_F        8'h9e

// ==========================================================
// reset value and field positions
`define MAC_RESET_WORD         32'h0000_0000
`define MAC_BIT_PARITY         31
`define MAC_BIT_DETECT_EN      30
`define MAC_BIT_BRAKE_EN       29
`define MAC_BIT_FLOAT_EN       28
`define MAC_BIT_REVERSE_EN     27
`define MAC_BIT_CATCH_EN       26
`define MAC_THR_MSB            25
`define MAC_THR_LSB            22
`define MAC_BLANK_MSB          20
`define MAC_BLANK_LSB          17
`define MAC_UNMAPPED_READ      32'h0000_0000

`endif

// >>> test/mac_chk_assertions.sv
// Purpose: port checks of the config bank
// Assumes: bound to mac_config_bank
// Notes: one clock domain
`timescale 1ns/1ns
`default_nettype none
module mac_chk import mac_pkg::*; #(parameter int NUM_WORDS = 14) (
    // all ports of the bank
    input wire logic clk_sys, resetn, wr_en, rd_en, rd_valid,
    input wire logic [7:0] addr,
    input wire logic [31:0] wr_data, rd_data,
    input wire mac_detect_ctl_t detect_ctl,
    input wire logic [NUM_WORDS*32-1:0] cfg_words);
    // field codes of the speed detect word
    logic [3:0] tc, bc;
    assign tc = cfg_words[25:22];
    assign bc = cfg_words[20:17];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!resetn);
    property p_rv; rd_en |=> rd_valid; endproperty
    a_rv: assert property (p_rv) else $error("read not answered");
    property p_wr; wr_en && addr == 8'h80 |=> cfg_words[31:0] == $past(wr_data); endproperty
    a_wr: assert property (p_wr) else $error("word 80 not written");
    property p_hold; !wr_en |=> $stable(cfg_words); endproperty
    a_hold: assert property (p_hold) else $error("word changed");
    property p_en; 1 |=> detect_ctl[21:17] == $past(cfg_words[30:26]); endproperty
    a_en: assert property (p_en) else $error("enable decode");
    property p_rd; rd_en && addr == 8'h80 |=> rd_data == $past(cfg_words[31:0]); endproperty
    a_rd: assert property (p_rd) else $error("read data");
    property p_unm; rd_en && addr == 8'h90 |=> rd_data == 32'h0; endproperty
    a_unm: assert property (p_unm) else $error("reserved read");
    property p_thr; 1 |=> detect_ctl.catch_spin_speed_threshold ==
        ($past(tc) < 12 ? 5 * $past(tc) + 5 : 10 * $past(tc) - 50); endproperty
    a_thr: assert property (p_thr) else $error("threshold decode");
    property p_blk; bc < 4'ha |=> detect_ctl.blanking_ns == 25 * $past(bc) + 25; endproperty
    a_blk: assert property (p_blk) else $error("blanking decode");
    property p_blk_hi; bc >= 4'ha |=> detect_ctl.blanking_ns > 10'h0fa; endproperty
    a_blk_hi: assert property (p_blk_hi) else $error("long blanking decode");
    c_wr: cover property (wr_en && addr == 8'h80);
    c_unm: cover property (rd_en && addr == 8'h90);
    c_both: cover property (wr_en && rd_en);
endmodule
bind mac_config_bank mac_chk #(.NUM_WORDS(NUM_WORDS)) u_chk (.clk_sys, .resetn, .wr_en,
    .rd_en, .rd_valid, .addr, .wr_data, .rd_data, .detect_ctl, .cfg_words);
`default_nettype wire

// >>> test/mac_host.sv
// Purpose: host side of the word access port
// Assumes: one access per falling edge
// Notes: writes only listed offsets
`timescale 1ns/1ns
`default_nettype none
module mac_host (
    // clock and access
    input wire logic   clk_sys,
    output logic       wr_en, rd_en,
    output logic [7:0] addr,
    output logic [31:0] wr_data);
    initial {wr_en, rd_en, addr, wr_data} = '0;
    // change on falling edge, held through taking edge
    task acc(logic w, r, logic [7:0] a, logic [31:0] v);
        @(negedge clk_sys);
        {wr_en, rd_en, addr, wr_data} = {w, r, a, v};
    endtask
endmodule
`default_nettype wire

// >>> test/tb_top.sv
// Purpose: self-checking bench of the config bank
// Assumes: host model drives accesses
// Notes: reads scored through a queue
`timescale 1ns/1ns
`default_nettype none
module tb_top import mac_pkg::*;;
    logic clk_sys, resetn, rd_valid, wr_en, rd_en;
    logic [7:0] addr;
    logic [31:0] wr_data, rd_data, d, e, m[14], q[$];
    mac_detect_ctl_t detect_ctl;
    int fail_count, total_checks, seed, i;
    mac_host host (.clk_sys, .wr_en, .rd_en, .addr, .wr_data);
    mac_config_bank dut (.clk_sys, .resetn, .wr_en, .rd_en, .addr, .wr_data, .rd_data,
        .rd_valid, .detect_ctl, .cfg_words());
    initial begin
        clk_sys = 0;
        forever #5 clk_sys = ~clk_sys;
    end
    function logic [7:0] off(int k); return 8'(k < 8 ? 128 + 2 * k : 132 + 2 * k); endfunction
    task chk(logic [31:0] s, e);
        total_checks++;
        if (s !== e) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, s, e);
        end
    endtask
    task wr(int k, logic [31:0] v); m[k] = v; host.acc(1, 0, off(k), v); endtask
    task rd(logic [7:0] a, logic [31:0] e); q.push_back(e); host.acc(0, 1, a, ~e); endtask
    task summarize;
        $display("checks %0d fails %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // scoreboard: oldest note against each read answer
    always @(negedge clk_sys) begin
        if (rd_valid === 1'b1 && q.size() == 0) chk(32'h1, 32'h0);
        else if (rd_valid === 1'b1) chk(rd_data, q.pop_front());
    end
    initial begin
        #5000;
        fail_count++;
        summarize;
    end
    initial begin
        seed = 32'h8806;
        resetn = 0;
        repeat (2) @(negedge clk_sys);
        resetn = 1;
        for (i = 0; i < 14; i++) rd(off(i), 0);
        rd(8'h90, 0);
        rd(8'h81, 0);
        for (i = 0; i < 14; i++) wr(i, $random(seed));
        for (i = 0; i < 14; i++) rd(off(i), m[i]);
        // every threshold and blanking code
        for (i = 0; i < 16; i++) begin
            d = $random(seed);
            d[25:22] = i[3:0];
            d[20:17] = i[3:0];
            wr(0, d);
            host.acc(0, 0, 8'h3c, ~d);
            @(negedge clk_sys);
            e = {10'h0, d[30:26], 7'(i < 12 ? 5 * i + 5 : 10 * i - 50),
                10'(i < 10 ? 25 * i + 25 : i < 15 ? 50 * i - 200 : 600)};
            chk({10'h0, detect_ctl}, e);
        end
        q.push_back(m[0]);
        host.acc(1, 1, 8'h80, 32'h1);
        rd(8'h80, 32'h1);
        host.acc(0, 0, 8'h3c, 0);
        repeat (2) @(negedge clk_sys);
        resetn = 0;
        repeat (2) @(negedge clk_sys);
        resetn = 1;
        rd(8'h80, 0);
        host.acc(0, 0, 8'h3c, 0);
        repeat (2) @(negedge clk_sys);
        chk(q.size(), 0);
        summarize;
    end
endmodule
`default_nettype wire
